// ---- rtl/dmcr_pkg.sv ----
package dmcr_pkg;
	// register indices, 7-bit field of the command word
	localparam logic [6:0] REG_MODE_C      = 7'h14;
	localparam logic [6:0] REG_ZERO_CTRL   = 7'h15;
	localparam logic [6:0] REG_ZERO_STATUS = 7'h16;
	localparam logic [6:0] REG_CHIP_ID     = 7'h17;
	// command word layout
	localparam int CMD_DIR_BIT  = 15;
	localparam int CMD_IDX_HI   = 14;
	localparam int CMD_IDX_LO   = 8;
	// mode_control_c bit positions
	localparam int MC_RESET_BIT = 6;
	localparam int MC_STREAM_BIT = 5;
	localparam int MC_BYPASS_BIT = 4;
	localparam int MC_MONO_BIT  = 3;
	localparam int MC_CHSEL_BIT = 2;
	// zero_flag_control bit positions
	localparam int ZC_PAT_HI    = 2;
	localparam int ZC_PAT_LO    = 1;
	localparam int ZC_MB_BIT    = 0;
	// reset values
	localparam logic [1:0] RST_RATE    = 2'h0;
	localparam logic [1:0] RST_PATTERN = 2'h0;
	localparam logic       RST_MB_EN   = 1'h1;
	// modulator rate codes
	localparam logic [1:0] RATE_X64  = 2'h0;
	localparam logic [1:0] RATE_X32  = 2'h1;
	localparam logic [1:0] RATE_X128 = 2'h2;
	// zero pattern codes
	localparam logic [1:0] PAT_OFF   = 2'h0;
	localparam logic [1:0] PAT_EVEN  = 2'h1;
	localparam logic [7:0] IDLE_PATTERN = 8'h96;
	// soft reset pulse length in cycles
	localparam logic [2:0] SOFT_RESET_CYCLES = 3'h4;
	// arbitrary neutral identifier
	localparam logic [4:0] DEVICE_ID_DEFAULT = 5'h0a;
	// operating mode of the data path
	typedef enum logic [2:0]
	{
		DMCR_MODE_MULTI  = 3'b001,
		DMCR_MODE_BYPASS = 3'b010,
		DMCR_MODE_STREAM = 3'b100
	} dmcr_mode_t;
endpackage

// ---- rtl/dmcr_sync.sv ----
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs
module dmcr_sync
(
	input  wire logic core_clk,
	input  wire logic sys_rst,
	input  wire logic pinIn,
	output logic      pinSync
);
	import dmcr_pkg::*;

	typedef struct packed
	{
		logic stage1;
		logic stage2;
	} dmcr_sync_t;

	dmcr_sync_t state;
	dmcr_sync_t next_state;

	// shift the pin through two stages
	always_comb
	begin
		next_state.stage1 = pinIn;
		next_state.stage2 = state.stage1;
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			state <= '0;
		else
			state <= next_state;
	end

	assign pinSync = state.stage2;
endmodule

// ---- rtl/dmcr_soft_reset.sv ----
`timescale 1ns/1ps
// stretches a one-cycle request into a fixed reset pulse
module dmcr_soft_reset
(
	input  wire logic core_clk,
	input  wire logic sys_rst,
	input  wire logic request,
	output logic      resetPulse
);
	import dmcr_pkg::*;

	typedef struct packed
	{
		logic [2:0] count;
		logic       active;
	} dmcr_soft_reset_pulse_t;

	dmcr_soft_reset_pulse_t state;
	dmcr_soft_reset_pulse_t next_state;

	// load on request, count down to the end of the pulse
	always_comb
	begin
		next_state = state;
		if (request && !state.active)
		begin
			next_state.active = 1'b1;
			next_state.count  = SOFT_RESET_CYCLES - 3'h1;
		end
		else if (state.active)
		begin
			if (state.count == 3'h0)
				next_state.active = 1'b0;
			else
				next_state.count = state.count - 3'h1;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			state <= '0;
		else
			state <= next_state;
	end

	assign resetPulse = state.active;
endmodule

// ---- rtl/dmcr_regs.sv ----
`timescale 1ns/1ps
// Contract
// - command bit 15 low means write, high means read.
// - writing one to the reset bit fires one internal reset pulse restoring defaults.
// - stream mode bit, read/write, resets zero, selects one-bit input mode.
// - bypass bit resets zero; set bypasses internal filter for external one.
// - mono bit set runs both channels balanced on one input channel.
// - channel select zero picks left, one right; acts only in mono. Code also uses it outside mono to pick the stream pin.
// - stream mono takes one-bit input from primary data input.
// - rate field 00 x64, 01 x32, 10 x128, 11 reserved; reset 00.
// - in stream mode rate field sets bit clock speed into analog filter.
// - pattern field 00 off, 01 even pattern, 1x hex 96 idle pattern.
// - multibit zero enable resets one; gates flags in multibit and bypass modes.
// - status register read-only, reads direction one, bit1 right, bit0 left.
// - status bits always equal the channel zero flag pins.
// - identifier register returns five-bit device identifier in low bits.
// - in bypass mode rate field means 8, 4, 16 times word clock.
module dmcr_regs
(
	input  wire logic                core_clk,
	input  wire logic                sys_rst,
	input  wire logic [4:0]          deviceIdentifier,
	input  wire logic                cmdValid,
	input  wire logic [15:0]         cmdWord,
	output logic [7:0]               readData,
	output logic                     readValid,
	output logic                     readError,
	input  wire logic                primaryDataPin,
	input  wire logic                rightStreamPin,
	input  wire logic                leftZeroDetect,
	input  wire logic                rightZeroDetect,
	input  wire logic [7:0]          leftStreamByte,
	input  wire logic [7:0]          rightStreamByte,
	output logic                     softResetPulse,
	output dmcr_pkg::dmcr_mode_t     operatingMode,
	output logic                     oneBitStreamMode,
	output logic                     filterBypassMode,
	output logic                     monoMode,
	output logic                     monoChannelSelect,
	output logic [1:0]               modulatorRateSelect,
	output logic [7:0]               oversampleRatio,
	output logic [4:0]               wordClockMultiple,
	output logic                     rateReserved,
	output logic                     streamBitIn,
	output logic [1:0]               bitstreamZeroPatternSelect,
	output logic                     multibitZeroFlagEnable,
	output logic                     leftZeroPin,
	output logic                     rightZeroPin
);
	import dmcr_pkg::*;

	////////////////////////////////////////////////////////////////
	// state

	typedef struct packed
	{
		logic       stream;
		logic       bypass;
		logic       mono;
		logic       chSel;
		logic [1:0] rate;
		logic [1:0] pattern;
		logic       mbEnable;
		logic       leftZero;
		logic       rightZero;
		logic       streamBit;
		logic [7:0] rdData;
		logic       rdValid;
		logic       rdError;
		logic       resetReq;
		logic [4:0] idLatch;
	} dmcr_regs_t;

	dmcr_regs_t state;
	dmcr_regs_t next_state;

	logic       primarySync;
	logic       rightSync;
	logic       isRead;
	logic [6:0] cmdIndex;
	logic [7:0] cmdData;
	logic       leftFlag;
	logic       rightFlag;
	logic       patternEnabled;
	logic       leftPatHit;
	logic       rightPatHit;
	logic       modeWrite;

	////////////////////////////////////////////////////////////////
	// pin synchronisers and reset pulse

	dmcr_sync u_syncPrimary
	(
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pinIn    (primaryDataPin),
		.pinSync  (primarySync)
	);

	dmcr_sync u_syncRight
	(
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pinIn    (rightStreamPin),
		.pinSync  (rightSync)
	);

	// one write of the reset bit gives one stretched pulse
	dmcr_soft_reset u_softReset
	(
		.core_clk   (core_clk),
		.sys_rst    (sys_rst),
		.request    (state.resetReq),
		.resetPulse (softResetPulse)
	);

	////////////////////////////////////////////////////////////////
	// command decode

	// split the command word
	assign isRead   = cmdWord[CMD_DIR_BIT];
	assign cmdIndex = cmdWord[CMD_IDX_HI:CMD_IDX_LO];
	assign cmdData  = cmdWord[7:0];

	// zero detection per mode
	assign patternEnabled = bitstreamZeroPatternSelect != PAT_OFF;
	always_comb
	begin
		if (bitstreamZeroPatternSelect[1])
		begin
			leftPatHit  = leftStreamByte == IDLE_PATTERN;
			rightPatHit = rightStreamByte == IDLE_PATTERN;
		end
		else
		begin
			leftPatHit  = leftStreamByte[0] == leftStreamByte[1] && leftStreamByte[2] == leftStreamByte[3];
			rightPatHit = rightStreamByte[0] == rightStreamByte[1] && rightStreamByte[2] == rightStreamByte[3];
		end
		if (state.stream)
		begin
			leftFlag  = patternEnabled && leftPatHit;
			rightFlag = patternEnabled && rightPatHit;
		end
		else
		begin
			leftFlag  = state.mbEnable && leftZeroDetect;
			rightFlag = state.mbEnable && rightZeroDetect;
		end
	end

	////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		next_state          = state;
		next_state.rdValid  = 1'b0;
		next_state.rdError  = 1'b0;
		next_state.resetReq = 1'b0;
		next_state.leftZero  = leftFlag;
		next_state.rightZero = rightFlag;
		// in mono stream mode the primary pin carries the data
		next_state.streamBit = (state.mono || !state.chSel) ? primarySync : rightSync;
		if (cmdValid && !isRead)
		begin
			case (cmdIndex)
				REG_MODE_C:
				begin
					next_state.resetReq = cmdData[MC_RESET_BIT];
					next_state.stream   = cmdData[MC_STREAM_BIT];
					next_state.bypass   = cmdData[MC_BYPASS_BIT];
					next_state.mono     = cmdData[MC_MONO_BIT];
					next_state.chSel    = cmdData[MC_CHSEL_BIT];
					next_state.rate     = cmdData[1:0];
				end
				REG_ZERO_CTRL:
				begin
					next_state.pattern  = cmdData[ZC_PAT_HI:ZC_PAT_LO];
					next_state.mbEnable = cmdData[ZC_MB_BIT];
				end
				default:
					next_state.rdError = 1'b1;
			endcase
		end
		else if (cmdValid && isRead)
		begin
			next_state.rdValid = 1'b1;
			case (cmdIndex)
				// reset bit always reads zero
				REG_MODE_C:
					next_state.rdData = {2'h0, state.stream, state.bypass, state.mono, state.chSel, state.rate};
				REG_ZERO_CTRL:
					next_state.rdData = {5'h00, state.pattern, state.mbEnable};
				REG_ZERO_STATUS:
					next_state.rdData = {6'h00, state.rightZero, state.leftZero};
				REG_CHIP_ID:
					next_state.rdData = {3'h0, state.idLatch};
				default:
				begin
					next_state.rdData  = 8'h00;
					next_state.rdError = 1'b1;
				end
			endcase
		end
		// soft reset restores every writable field, not the flags, read data or identifier
		if (softResetPulse)
		begin
			next_state.stream   = 1'b0;
			next_state.bypass   = 1'b0;
			next_state.mono     = 1'b0;
			next_state.chSel    = 1'b0;
			next_state.rate     = RST_RATE;
			next_state.pattern  = RST_PATTERN;
			next_state.mbEnable = RST_MB_EN;
		end
		next_state.idLatch = deviceIdentifier;
	end

	// identifier strap is caught after release, not at reset
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state          <= '0;
			state.rate     <= RST_RATE;
			state.pattern  <= RST_PATTERN;
			state.mbEnable <= RST_MB_EN;
			state.idLatch  <= DEVICE_ID_DEFAULT;
		end
		else
			state <= next_state;
	end

	////////////////////////////////////////////////////////////////
	// outputs

	assign readData                   = state.rdData;
	assign readValid                  = state.rdValid;
	assign readError                  = state.rdError;
	assign oneBitStreamMode           = state.stream;
	assign filterBypassMode           = state.bypass;
	assign monoMode                   = state.mono;
	assign monoChannelSelect          = state.mono & state.chSel;
	assign modulatorRateSelect        = state.rate;
	assign rateReserved               = &state.rate;
	assign streamBitIn                = state.streamBit;
	assign bitstreamZeroPatternSelect = state.pattern;
	assign multibitZeroFlagEnable     = state.mbEnable;
	assign leftZeroPin                = state.leftZero;
	assign rightZeroPin               = state.rightZero;
	assign operatingMode = state.stream ? DMCR_MODE_STREAM : (state.bypass ? DMCR_MODE_BYPASS : DMCR_MODE_MULTI);

	// rate decode per mode; stream mode uses the same ratio for bit clock
	always_comb
	begin
		case (state.rate)
			RATE_X64:  oversampleRatio = 8'd64;
			RATE_X32:  oversampleRatio = 8'd32;
			RATE_X128: oversampleRatio = 8'd128;
			default:   oversampleRatio = 8'd0;
		endcase
		case (state.rate)
			RATE_X64:  wordClockMultiple = 5'd8;
			RATE_X32:  wordClockMultiple = 5'd4;
			RATE_X128: wordClockMultiple = 5'd16;
			default:   wordClockMultiple = 5'd0;
		endcase
		if (!state.bypass)
			wordClockMultiple = 5'd0;
	end

	////////////////////////////////////////////////////////////////
	// checks

	chk_write_dir_read: assert property (@(posedge core_clk) disable iff (sys_rst)
		cmdValid && cmdWord[15] |=> readValid)
		else $error("read command gave no answer");
	chk_reset_pulse_fires: assert property (@(posedge core_clk) disable iff (sys_rst)
		cmdValid && !cmdWord[15] && cmdWord[14:8] == 7'h14 && cmdWord[6] && !softResetPulse |-> ##2 softResetPulse)
		else $error("soft reset pulse missing");
	chk_reset_restores: assert property (@(posedge core_clk) disable iff (sys_rst)
		$fell(softResetPulse) |-> !oneBitStreamMode && !monoMode && modulatorRateSelect == 2'h0 && multibitZeroFlagEnable)
		else $error("soft reset did not restore defaults");
	chk_mode_write: assert property (@(posedge core_clk) disable iff (sys_rst)
		cmdValid && !cmdWord[15] && cmdWord[14:8] == 7'h14 && !softResetPulse |=> oneBitStreamMode == $past(cmdWord[5]))
		else $error("stream mode not written");
	chk_chsel_gated: assert property (@(posedge core_clk) disable iff (sys_rst)
		!monoMode |-> !monoChannelSelect)
		else $error("channel select active outside mono");
	chk_mono_primary: assert property (@(posedge core_clk) disable iff (sys_rst)
		monoMode && $stable(monoMode) |=> streamBitIn == $past(primarySync))
		else $error("mono stream not from primary input");
	chk_rate_decode: assert property (@(posedge core_clk) disable iff (sys_rst)
		modulatorRateSelect == 2'h2 |-> oversampleRatio == 8'd128)
		else $error("rate decode wrong");
	chk_mb_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
		!oneBitStreamMode && !multibitZeroFlagEnable && $stable(multibitZeroFlagEnable) |=> !leftZeroPin && !rightZeroPin)
		else $error("zero flag not suppressed");
	chk_status_pins: assert property (@(posedge core_clk) disable iff (sys_rst)
		cmdValid && cmdWord[15] && cmdWord[14:8] == 7'h16 |=> readData == {6'h00, $past(rightZeroPin), $past(leftZeroPin)})
		else $error("status differs from pins");
	chk_id_read: assert property (@(posedge core_clk) disable iff (sys_rst)
		cmdValid && cmdWord[15] && cmdWord[14:8] == 7'h17 |=> readData[7:5] == 3'h0)
		else $error("identifier upper bits not zero");
	chk_bypass_rate: assert property (@(posedge core_clk) disable iff (sys_rst)
		filterBypassMode && modulatorRateSelect == 2'h1 |-> wordClockMultiple == 5'd4)
		else $error("word clock multiple wrong");

	// a mode write that no soft reset pulse overrides
	assign modeWrite = cmdValid && !isRead && cmdIndex == REG_MODE_C && !softResetPulse;

	chk_write_silent: assert property (@(posedge core_clk) disable iff (sys_rst)
		cmdValid && !cmdWord[CMD_DIR_BIT] |=> !readValid)
		else $error("write command gave a read answer");
	chk_pulse_length: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(softResetPulse) |-> softResetPulse [*4] ##1 !softResetPulse)
		else $error("soft reset pulse length wrong");
	chk_bypass_write: assert property (@(posedge core_clk) disable iff (sys_rst)
		modeWrite |=> filterBypassMode == $past(cmdWord[MC_BYPASS_BIT]))
		else $error("bypass mode not written");
	chk_mono_write: assert property (@(posedge core_clk) disable iff (sys_rst)
		modeWrite |=> monoMode == $past(cmdWord[MC_MONO_BIT]))
		else $error("mono mode not written");
	chk_chsel_write: assert property (@(posedge core_clk) disable iff (sys_rst)
		modeWrite |=> monoChannelSelect == ($past(cmdWord[MC_MONO_BIT]) && $past(cmdWord[MC_CHSEL_BIT])))
		else $error("channel select not written");
	chk_rate_write: assert property (@(posedge core_clk) disable iff (sys_rst)
		modeWrite |=> modulatorRateSelect == $past(cmdWord[1:0]))
		else $error("rate field not written");
	chk_stream_zero_off: assert property (@(posedge core_clk) disable iff (sys_rst)
		oneBitStreamMode && bitstreamZeroPatternSelect == PAT_OFF |=> !leftZeroPin && !rightZeroPin)
		else $error("stream zero flag while disabled");
	chk_ro_write_refused: assert property (@(posedge core_clk) disable iff (sys_rst)
		cmdValid && !isRead && (cmdIndex == REG_ZERO_STATUS || cmdIndex == REG_CHIP_ID) |=> readError)
		else $error("write to read-only register not refused");

	cov_soft_reset: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(softResetPulse));
	cov_stream_mono: cover property (@(posedge core_clk) disable iff (sys_rst) oneBitStreamMode && monoMode);
	cov_status_read: cover property (@(posedge core_clk) disable iff (sys_rst)
		readValid && readData[1:0] == 2'h3);
	cov_bypass_x128: cover property (@(posedge core_clk) disable iff (sys_rst)
		filterBypassMode && modulatorRateSelect == RATE_X128);
	cov_write_refused: cover property (@(posedge core_clk) disable iff (sys_rst) readError && !readValid);
endmodule

// ---- verif/dmcr_host.sv ----
`timescale 1ns/1ps
// host side of the command port
module dmcr_host
(
	input  wire logic       core_clk,
	output logic            cmdValid,
	output logic [15:0]     cmdWord,
	input  wire logic [7:0] readData,
	input  wire logic       readValid,
	input  wire logic       readError
);
	// idle port at time zero
	initial
	begin
		cmdValid = 1'b0;
		cmdWord = 16'h0000;
	end
	// one whole word per command, answer flags gathered over two cycles
	task automatic xfer(input logic [15:0] w, output logic [7:0] d, output logic v, output logic e);
		v = 1'b0;
		e = 1'b0;
		d = 8'h00;
		@(negedge core_clk);
		cmdValid = 1'b1;
		cmdWord = w;
		@(negedge core_clk);
		cmdValid = 1'b0;
		cmdWord = ~w; // released word never shows the last value
		repeat (2)
		begin
			d = (readValid === 1'b1) ? readData : d;
			v = v | (readValid === 1'b1);
			e = e | (readError === 1'b1);
			@(negedge core_clk);
		end
	endtask
endmodule

// ---- verif/dac_mode_control_registers_tb.sv ----
`timescale 1ns/1ps
// self-checking bench for the mode-control registers
module dac_mode_control_registers_tb;
	import dmcr_pkg::*;
	logic              core_clk;
	logic              sys_rst;
	logic [4:0]        devId;
	logic              cmdValid;
	logic [15:0]       cmdWord;
	logic [7:0]        readData;
	logic              readValid;
	logic              readError;
	logic              priPin;
	logic              rightPin;
	logic              lZero;
	logic              rZero;
	logic [7:0]        lByte;
	logic [7:0]        rByte;
	logic              pulse;
	dmcr_mode_t        opMode;
	logic              monoSel;
	logic [7:0]        ratio;
	logic [4:0]        wck;
	logic              rateResv;
	logic              bitIn;
	logic              lPin;
	logic              rPin;
	logic              streamMode;
	logic              bypassMode;
	logic              monoOn;
	logic [1:0]        rateSel;
	logic [1:0]        patSel;
	logic              mbEn;
	int                numErrors = 0;
	int                nTests = 0;
	int                pulseCycles = 0;
	// element 0 sits at the right end
	localparam logic [3:0][7:0] ratioTable = {8'h00, 8'h80, 8'h20, 8'h40};
	localparam logic [3:0][7:0] wckTable = {8'h00, 8'h10, 8'h04, 8'h08};

	////////////////////////////////////////////////////////////////
	// device and host
	dmcr_regs u_dut
	(
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.deviceIdentifier(devId),
		.cmdValid(cmdValid),
		.cmdWord(cmdWord),
		.readData(readData),
		.readValid(readValid),
		.readError(readError),
		.primaryDataPin(priPin),
		.rightStreamPin(rightPin),
		.leftZeroDetect(lZero),
		.rightZeroDetect(rZero),
		.leftStreamByte(lByte),
		.rightStreamByte(rByte),
		.softResetPulse(pulse),
		.operatingMode(opMode),
		.oneBitStreamMode(streamMode),
		.filterBypassMode(bypassMode),
		.monoMode(monoOn),
		.monoChannelSelect(monoSel),
		.modulatorRateSelect(rateSel),
		.oversampleRatio(ratio),
		.wordClockMultiple(wck),
		.rateReserved(rateResv),
		.streamBitIn(bitIn),
		.bitstreamZeroPatternSelect(patSel),
		.multibitZeroFlagEnable(mbEn),
		.leftZeroPin(lPin),
		.rightZeroPin(rPin)
	);
	dmcr_host u_host
	(
		.core_clk(core_clk),
		.cmdValid(cmdValid),
		.cmdWord(cmdWord),
		.readData(readData),
		.readValid(readValid),
		.readError(readError)
	);

	////////////////////////////////////////////////////////////////
	// clock, pulse length counter, watchdog
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
		pulseCycles <= pulseCycles + (pulse === 1'b1);
	initial
	begin
		#100000;
		numErrors++;
		conclude();
	end

	////////////////////////////////////////////////////////////////
	// compare, access and verdict tasks
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		nTests++;
		if (g !== e)
		begin
			numErrors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic acc(input logic r, input logic [6:0] a, input logic [7:0] x, input logic [7:0] ed, input logic ee);
		logic [7:0] d;
		logic       v;
		logic       e;
		u_host.xfer({r, a, x}, d, v, e);
		chk("error", {7'h00, ee}, {7'h00, e});
		if (r && !ee)
		begin
			chk("valid", 8'h01, {7'h00, v});
			chk("data", ed, d);
		end
		else if (!r)
			chk("valid", 8'h00, {7'h00, v});
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] x);
		acc(1'b0, a, x, 8'h00, 1'b0);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] ed);
		acc(1'b1, a, 8'h00, ed, 1'b0);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", nTests, numErrors);
		if (numErrors == 0 && nTests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// test sequence
	initial
	begin
		sys_rst = 1'b1;
		devId = 5'h13;
		priPin = 1'b0;
		rightPin = 1'b0;
		lZero = 1'b0;
		rZero = 1'b0;
		lByte = 8'h00;
		rByte = 8'h00;
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		sys_rst = 1'b0;
		// reset values
		rd(REG_MODE_C, 8'h00);
		rd(REG_ZERO_CTRL, 8'h01);
		rd(REG_ZERO_STATUS, 8'h00);
		rd(REG_CHIP_ID, {3'h0, devId});
		chk("mode", {5'h00, DMCR_MODE_MULTI}, {5'h00, opMode});
		// every rate code, internal filter then bypass
		for (int b = 0; b < 2; b++)
			for (int r = 0; r < 4; r++)
			begin
				wr(REG_MODE_C, 8'(b * 16 + r));
				rd(REG_MODE_C, 8'(b * 16 + r));
				chk("ratio", ratioTable[r], ratio);
				chk("rate", 8'(r), {6'h00, rateSel});
				chk("bypass", 8'(b), {7'h00, bypassMode});
				chk("wck", (b == 1) ? wckTable[r] : 8'h00, {3'h0, wck});
				chk("resv", {7'h00, r == 3}, {7'h00, rateResv});
				chk("mode", {5'h00, (b == 1) ? DMCR_MODE_BYPASS : DMCR_MODE_MULTI}, {5'h00, opMode});
			end
		// stream mode set before stream data arrives
		wr(REG_MODE_C, 8'h24);
		rightPin = 1'b1;
		repeat (4) @(negedge core_clk);
		chk("bit", 8'h01, {7'h00, bitIn});
		chk("monosel", 8'h00, {7'h00, monoSel});
		chk("mode", {5'h00, DMCR_MODE_STREAM}, {5'h00, opMode});
		chk("stream", 8'h01, {7'h00, streamMode});
		wr(REG_MODE_C, 8'h2c);
		repeat (4) @(negedge core_clk);
		chk("bit", 8'h00, {7'h00, bitIn});
		chk("monosel", 8'h01, {7'h00, monoSel});
		chk("mono", 8'h01, {7'h00, monoOn});
		// stream zero patterns, multibit detect ignored here
		lByte = IDLE_PATTERN;
		rByte = 8'h33; // both low bit pairs equal, not idle
		lZero = 1'b1;
		rZero = 1'b1;
		for (int p = 0; p < 4; p++)
		begin
			wr(REG_ZERO_CTRL, {5'h00, 2'(p), 1'b1});
			repeat (2) @(negedge core_clk);
			chk("zero", {6'h00, p == 1, p[1]}, {6'h00, rPin, lPin});
			chk("pattern", 8'(p), {6'h00, patSel});
			rd(REG_ZERO_STATUS, {6'h00, p == 1, p[1]});
		end
		// multibit zero flags and their enable
		wr(REG_MODE_C, 8'h00);
		rZero = 1'b0;
		repeat (2) @(negedge core_clk);
		chk("zero", 8'h01, {6'h00, rPin, lPin});
		rd(REG_ZERO_STATUS, 8'h01);
		wr(REG_ZERO_CTRL, 8'h00);
		repeat (2) @(negedge core_clk);
		chk("zero", 8'h00, {6'h00, rPin, lPin});
		chk("mbenable", 8'h00, {7'h00, mbEn});
		// refused accesses
		acc(1'b0, REG_ZERO_STATUS, 8'h03, 8'h00, 1'b1);
		acc(1'b0, REG_CHIP_ID, 8'h1f, 8'h00, 1'b1);
		acc(1'b1, 7'h30, 8'h00, 8'h00, 1'b1);
		rd(REG_ZERO_STATUS, 8'h00);
		// soft reset restores every writable field
		wr(REG_ZERO_CTRL, 8'h06);
		wr(REG_MODE_C, 8'h7e);
		repeat (8) @(negedge core_clk);
		chk("pulse", {5'h00, SOFT_RESET_CYCLES}, 8'(pulseCycles));
		rd(REG_MODE_C, 8'h00);
		rd(REG_ZERO_CTRL, 8'h01);
		chk("mbenable", 8'h01, {7'h00, mbEn});
		chk("mode", {5'h00, DMCR_MODE_MULTI}, {5'h00, opMode});
		conclude();
	end
endmodule
